// ===== design/timer_compare_pkg.sv
// Constants, register map and types of the compact compare-match timer.
// Assumes one clock and a plain strobe register port around the block.
// ****************************************************************
// Function
// - Clear-select high clears counter on A match; low clears on P match.
// - With clear-select low, overflow clears only when compare P is zero.
// - PWM mode ignores clear-select for choosing the clear source.
// - Two-bit mode field picks compare output, PWM or timer/counter.
// - Mode field 00 selects compare match output mode.
// - Clear-select low in compare mode raises both A and P flags.
// - Outside PWM mode, clear-select high never raises the P flag, only the A flag.
// - Clear-select high and compare A zero: overflow at 3FF, no A flag.
// - In compare mode the pin changes only on an A match with A flag, or on an enable rising edge.
// - P matches and the P flag never touch the output pin.
// - In compare mode, on A match the output-action field drives the pin low, high or toggles.
// - Output-action field zero leaves the pin unchanged.
// - Enable rising edge loads the pin with the initial level bit.
// - Compare mode clears on overflow, A match or P match.
// - Mode field 10 selects PWM output mode.
// - Mode field 11 is timer/counter: same flags, pin unused.
// - Polarity bit inverts the pin; no effect in timer/counter mode.
// ****************************************************************
package timer_compare_pkg;

   // ************************************************************
   // Bus and counter widths
   // ************************************************************
   localparam int ADDR_W     = 8;
   localparam int DATA_W     = 32;
   localparam int COUNT_W    = 10;
   localparam int CMPP_W     = 3;
   localparam int STATUS_W   = 2;

   // ************************************************************
   // Register offsets
   // ************************************************************
   localparam logic [ADDR_W-1:0] OFS_ENABLE  = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_CMP_A   = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_CMP_P   = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_COUNT   = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_MASK    = 8'h18;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int POS_TIMER_ENABLE = 0;
   localparam int POS_CLEAR_SELECT = 0;
   localparam int POS_DUTY_SWAP    = 1;
   localparam int POS_POLARITY     = 2;
   localparam int POS_INIT_LEVEL   = 3;
   localparam int POS_ACTION_LO    = 4;
   localparam int POS_MODE_LO      = 6;
   localparam int POS_FLAG_A       = 0;
   localparam int POS_FLAG_P       = 1;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [7:0]          RST_CONTROL = 8'h00;
   localparam logic [COUNT_W-1:0]  RST_CMP_A   = 10'h000;
   localparam logic [CMPP_W-1:0]   RST_CMP_P   = 3'h0;
   localparam logic [STATUS_W-1:0] RST_STATUS  = 2'h0;
   localparam logic [STATUS_W-1:0] RST_MASK    = 2'h0;

   // ************************************************************
   // Modes and output actions
   // ************************************************************
   typedef enum logic [1:0]
   {
      MODE_COMPARE = 2'b00,
      MODE_SPARE   = 2'b01,
      MODE_PWM     = 2'b10,
      MODE_TIMER   = 2'b11
   } mode_type;

   typedef enum logic [1:0]
   {
      ACT_NONE   = 2'b00,
      ACT_LOW    = 2'b01,
      ACT_HIGH   = 2'b10,
      ACT_TOGGLE = 2'b11
   } action_type;

endpackage : timer_compare_pkg

// ===== design/event_status_reg.sv
// Sticky event bits with clear-on-read, set winning over clear.
// Assumes events and the read clear come from the same clock.
`timescale 1ns/1ps
module event_status_reg
#(
   parameter int WIDTH = 2
)
(
   input  wire logic             ref_clk,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] setEvents,
   input  wire logic             clearAll,
   output      logic [WIDTH-1:0] status
);
   import timer_compare_pkg::*;

   logic [WIDTH-1:0] status_reg;
   logic [WIDTH-1:0] status_next;

   // ************************************************************
   // Elaboration check
   // ************************************************************
   if (WIDTH < 1)
   begin : g_bad_width
      $error("event_status_reg needs at least one bit");
   end

   // Event in the clearing cycle survives
   assign status_next = (status_reg & ~{WIDTH{clearAll}}) | setEvents;
   assign status      = status_reg;

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         status_reg <= '0;
      else
         status_reg <= status_next;
   end

endmodule : event_status_reg

// ===== design/compact_timer_compare_match.sv
// Compact timer core: counter, comparators A and P, output pin control.
// Assumes a register master on ref_clk; the count rate is ref_clk.
`timescale 1ns/1ps
module compact_timer_compare_match
#(
   parameter int COUNT_WIDTH = timer_compare_pkg::COUNT_W,
   parameter int CMPP_WIDTH  = timer_compare_pkg::CMPP_W
)
(
   input  wire logic                                 ref_clk,
   input  wire logic                                 reset_n,
   input  wire logic [timer_compare_pkg::ADDR_W-1:0] busAddr,
   input  wire logic [timer_compare_pkg::DATA_W-1:0] busWriteData,
   input  wire logic                                 busWrite,
   input  wire logic                                 busRead,
   output      logic [timer_compare_pkg::DATA_W-1:0] busReadData,
   output      logic                                 tmOut,
   output      logic                                 tmOutEnable,
   output      logic                                 irq
);
   import timer_compare_pkg::*;

   localparam int LOW_W = COUNT_WIDTH - CMPP_WIDTH;

   // ************************************************************
   // Elaboration check
   // ************************************************************
   if (CMPP_WIDTH < 1 || CMPP_WIDTH >= COUNT_WIDTH || COUNT_WIDTH > 16)
   begin : g_bad_widths
      $error("compare P must be narrower than the counter");
   end

   // ************************************************************
   // Register state
   // ************************************************************
   logic                   enable_reg;
   logic                   enablePrev_reg;
   logic [7:0]             control_reg;
   logic [COUNT_WIDTH-1:0] cmpA_reg;
   logic [CMPP_WIDTH-1:0]  cmpP_reg;
   logic [STATUS_W-1:0]    mask_reg;
   logic [COUNT_WIDTH-1:0] count_reg;
   logic [COUNT_WIDTH-1:0] count_next;
   logic                   outLevel_reg;
   logic                   outLevel_next;
   logic                   tmOut_reg;
   logic [DATA_W-1:0]      readData_reg;
   logic [DATA_W-1:0]      readData_next;
   logic [STATUS_W-1:0]    status;

   // ************************************************************
   // Register decode
   // ************************************************************
   wire hitEnable  = busAddr == OFS_ENABLE;
   wire hitControl = busAddr == OFS_CONTROL;
   wire hitCmpA    = busAddr == OFS_CMP_A;
   wire hitCmpP    = busAddr == OFS_CMP_P;
   wire hitCount   = busAddr == OFS_COUNT;
   wire hitStatus  = busAddr == OFS_STATUS;
   wire hitMask    = busAddr == OFS_MASK;
   wire statusRead = busRead && hitStatus;

   // ************************************************************
   // Control fields
   // ************************************************************
   wire        clearSelect = control_reg[POS_CLEAR_SELECT];
   wire        dutySwap    = control_reg[POS_DUTY_SWAP];
   wire        polarity    = control_reg[POS_POLARITY];
   wire        initLevel   = control_reg[POS_INIT_LEVEL];
   wire [1:0]  actionBits  = control_reg[POS_ACTION_LO +: 2];
   wire [1:0]  modeBits    = control_reg[POS_MODE_LO +: 2];

   mode_type   mode;
   action_type action;
   assign mode   = mode_type'(modeBits);
   assign action = action_type'(actionBits);

   // Spare code 01 behaves as timer/counter, pin idle
   wire modeCompare = mode == MODE_COMPARE;
   wire modePwm     = mode == MODE_PWM;
   wire modeTimer   = !modeCompare && !modePwm;

   // ************************************************************
   // Counter and comparators
   // ************************************************************
   wire enableRise = enable_reg && !enablePrev_reg;
   wire running    = enable_reg && !enableRise;

   wire [COUNT_WIDTH-1:0] countMax  = {COUNT_WIDTH{1'b1}};
   wire [COUNT_WIDTH-1:0] pTop      = {cmpP_reg, {LOW_W{1'b0}}};
   // Zero P value wraps past the top: period is the full range
   wire [COUNT_WIDTH-1:0] pLast     = COUNT_WIDTH'(pTop - 1'b1);
   wire cmpAZero = cmpA_reg == '0;
   wire cmpPZero = cmpP_reg == '0;

   // A match is blocked at zero so a cleared counter is no match
   wire matchA   = running && !cmpAZero && count_reg == cmpA_reg;
   wire overflow = running && count_reg == countMax;
   wire matchP   = running && count_reg == pLast;

   // PWM picks its period register by the swap bit
   wire useAClear = modePwm ? dutySwap : clearSelect;
   // P path covers overflow when P is zero; A path wraps at top
   wire counterClear = useAClear ? matchA : matchP;

   wire eventA = matchA;
   wire eventP = matchP && (modePwm || !clearSelect);

   always_comb
   begin
      if (enableRise)
         count_next = '0;
      else if (!running)
         count_next = count_reg;
      else if (counterClear)
         count_next = '0;
      else
         count_next = COUNT_WIDTH'(count_reg + 1'b1);
   end

   // ************************************************************
   // Output pin
   // ************************************************************
   wire pinChange = modeCompare && eventA;

   always_comb
   begin
      outLevel_next = outLevel_reg;
      if (enableRise)
         outLevel_next = initLevel;
      else if (pinChange)
      begin
         case (action)
            ACT_NONE:   outLevel_next = outLevel_reg;
            ACT_LOW:    outLevel_next = 1'b0;
            ACT_HIGH:   outLevel_next = 1'b1;
            ACT_TOGGLE: outLevel_next = !outLevel_reg;
            default:    outLevel_next = outLevel_reg;
         endcase
      end
   end

   // ************************************************************
   // Interrupt status
   // ************************************************************
   logic [STATUS_W-1:0] setEvents;
   assign setEvents[POS_FLAG_A] = eventA;
   assign setEvents[POS_FLAG_P] = eventP;

   event_status_reg
   #(
      .WIDTH     (STATUS_W)
   )
   u_status
   (
      .ref_clk   (ref_clk),
      .reset_n   (reset_n),
      .setEvents (setEvents),
      .clearAll  (statusRead),
      .status    (status)
   );

   assign irq = |(status & mask_reg);

   // ************************************************************
   // Read mux
   // ************************************************************
   always_comb
   begin
      readData_next = '0;
      if (busRead)
      begin
         if (hitEnable)
            readData_next[POS_TIMER_ENABLE] = enable_reg;
         else if (hitControl)
            readData_next[7:0] = control_reg;
         else if (hitCmpA)
            readData_next[COUNT_WIDTH-1:0] = cmpA_reg;
         else if (hitCmpP)
            readData_next[CMPP_WIDTH-1:0] = cmpP_reg;
         else if (hitCount)
            readData_next[COUNT_WIDTH-1:0] = count_reg;
         else if (hitStatus)
            readData_next[STATUS_W-1:0] = status;
         else if (hitMask)
            readData_next[STATUS_W-1:0] = mask_reg;
      end
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         enable_reg  <= 1'b0;
         control_reg <= RST_CONTROL;
         cmpA_reg    <= RST_CMP_A;
         cmpP_reg    <= RST_CMP_P;
         mask_reg    <= RST_MASK;
      end
      else if (busWrite)
      begin
         if (hitEnable)
            enable_reg <= busWriteData[POS_TIMER_ENABLE];
         if (hitControl)
            control_reg <= busWriteData[7:0];
         if (hitCmpA)
            cmpA_reg <= busWriteData[COUNT_WIDTH-1:0];
         if (hitCmpP)
            cmpP_reg <= busWriteData[CMPP_WIDTH-1:0];
         if (hitMask)
            mask_reg <= busWriteData[STATUS_W-1:0];
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         enablePrev_reg <= 1'b0;
         count_reg      <= '0;
         outLevel_reg   <= 1'b0;
         tmOut_reg      <= 1'b0;
         readData_reg   <= '0;
      end
      else
      begin
         enablePrev_reg <= enable_reg;
         count_reg      <= count_next;
         outLevel_reg   <= outLevel_next;
         // Polarity takes effect one cycle late, glitch free
         tmOut_reg      <= outLevel_next ^ polarity;
         readData_reg   <= readData_next;
      end
   end

   assign busReadData = readData_reg;
   assign tmOut       = tmOut_reg;
   // Pin released in timer/counter mode, so polarity is moot there
   assign tmOutEnable = !modeTimer;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   chk_clear_on_a: assert property (
      useAClear && matchA |=> count_reg == '0)
      else $error("counter not cleared by A match");

   chk_clear_on_p: assert property (
      !useAClear && matchP |=> count_reg == '0)
      else $error("counter not cleared by P match");

   chk_overflow_only: assert property (
      running && !useAClear && !cmpPZero && count_reg < pLast
      |=> count_reg == $past(count_reg) + 1'b1)
      else $error("counter cleared before P period end");

   chk_pwm_ignores_sel: assert property (
      modePwm && !dutySwap && matchA && !matchP && !overflow
      |=> count_reg == $past(count_reg) + 1'b1)
      else $error("PWM cleared by A while P governs");

   chk_flags_both: assert property (
      modeCompare && !clearSelect && matchP |=> status[POS_FLAG_P])
      else $error("P flag missing with clear-select low");

   chk_p_flag_blocked: assert property (
      !modePwm && clearSelect && !status[POS_FLAG_P]
      |=> !status[POS_FLAG_P])
      else $error("P flag raised with clear-select high");

   chk_a_zero_wrap: assert property (
      running && clearSelect && !modePwm && cmpAZero
      && count_reg == countMax && !status[POS_FLAG_A]
      |=> count_reg == '0 && !status[POS_FLAG_A])
      else $error("zero compare A misbehaves at overflow");

   chk_pin_hold: assert property (
      !pinChange && !enableRise |=> $stable(outLevel_reg))
      else $error("pin moved without A match");

   chk_pin_low: assert property (
      pinChange && !enableRise && action == ACT_LOW
      |=> !outLevel_reg ##1 !tmOut_reg ^ $past(polarity))
      else $error("pin not driven low on A match");

   chk_pin_none: assert property (
      pinChange && action == ACT_NONE && !enableRise
      |=> $stable(outLevel_reg))
      else $error("pin changed with action none");

   chk_init_level: assert property (
      enableRise |=> outLevel_reg == $past(initLevel))
      else $error("initial level not loaded");

   chk_enable_clear: assert property (
      enableRise |=> count_reg == '0 ##1 count_reg <= 1)
      else $error("counter not cleared on enable");

   chk_polarity_out: assert property (
      1'b1 |=> tmOut_reg == (outLevel_reg ^ $past(polarity)))
      else $error("pin polarity wrong");

   cov_toggle: cover property (
      pinChange && action == ACT_TOGGLE ##1 $changed(outLevel_reg));
   cov_p_flag: cover property (eventP ##1 irq);
   cov_overflow: cover property (overflow ##1 count_reg == '0);
   cov_enable: cover property (enableRise ##1 running);

endmodule : compact_timer_compare_match

// ===== tb/tb.sv
// Self-checking bench for the compact compare-match timer.
// Assumes the design package is compiled first and one 20 MHz clock.
`timescale 1ns/1ps
module tb;
   import timer_compare_pkg::*;

   // ************************************************************
   // Signals
   // ************************************************************
   logic              ref_clk      = 1'b0;
   logic              reset_n      = 1'b0;
   logic [ADDR_W-1:0] busAddr      = 8'h00;
   logic [DATA_W-1:0] busWriteData = 32'h0;
   logic              busWrite     = 1'b0;
   logic              busRead      = 1'b0;
   logic [DATA_W-1:0] busReadData;
   logic              tmOut;
   logic              tmOutEnable;
   logic              irq;
   logic [1:0]        maskVal      = 2'h0;
   logic [DATA_W-1:0] rdata;
   int                miscompares  = 0;
   int                checks       = 0;

   always #25 ref_clk = ~ref_clk;

   compact_timer_compare_match dut
   (
      .ref_clk      (ref_clk),
      .reset_n      (reset_n),
      .busAddr      (busAddr),
      .busWriteData (busWriteData),
      .busWrite     (busWrite),
      .busRead      (busRead),
      .busReadData  (busReadData),
      .tmOut        (tmOut),
      .tmOutEnable  (tmOutEnable),
      .irq          (irq)
   );

   // ************************************************************
   // Compare and bus tasks
   // ************************************************************
   task automatic cmpWord(input string what, input logic [31:0] exp,
                          input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : cmpWord

   task automatic cmpBit(input string what, input logic exp,
                         input logic got);
      checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH %s expected %b seen %b", what, exp, got);
      end
   endtask : cmpBit

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      busWrite     <= 1'b1;
      busAddr      <= a;
      busWriteData <= d;
      @(posedge ref_clk);
      busWrite <= 1'b0;
   endtask : wr

   // Data stands only in the cycle after the read edge
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk);
      busRead <= 1'b1;
      busAddr <= a;
      @(posedge ref_clk);
      busRead <= 1'b0;
      #1;
      rdata = busReadData;
   endtask : rd

   function automatic logic [31:0] ctl(input logic [1:0] md,
      input logic [1:0] act, input logic ini, input logic pol,
      input logic sel);
      return {24'h0, md, act, ini, pol, 1'b0, sel};
   endfunction : ctl

   // Count after stop is (n+1) mod period; stopping first keeps the
   // count read free of read-latency guesses
   task automatic run(input logic [31:0] c, input logic [9:0] a,
      input logic [2:0] p, input int n, input logic [9:0] expCnt,
      input logic [1:0] expSt, input logic expOut);
      rd(OFS_STATUS);
      wr(OFS_CONTROL, c);
      wr(OFS_CMP_A, {22'h0, a});
      wr(OFS_CMP_P, {29'h0, p});
      wr(OFS_ENABLE, 32'h1);
      repeat (n) @(posedge ref_clk);
      wr(OFS_ENABLE, 32'h0);
      rd(OFS_COUNT);
      cmpWord("count", {22'h0, expCnt}, rdata);
      cmpBit("pin", expOut, tmOut);
      cmpBit("irq", |(expSt & maskVal), irq);
      rd(OFS_STATUS);
      cmpWord("status", {30'h0, expSt}, rdata);
      rd(OFS_STATUS);
      cmpWord("status cleared", 32'h0, rdata);
      cmpBit("irq cleared", 1'b0, irq);
   endtask : run

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_reset;
      logic [7:0] addrs [8];
      addrs = '{OFS_ENABLE, OFS_CONTROL, OFS_CMP_A, OFS_CMP_P,
                OFS_COUNT, OFS_STATUS, OFS_MASK, 8'h1c};
      cmpBit("reset pin", 1'b0, tmOut);
      cmpBit("reset pin enable", 1'b1, tmOutEnable);
      cmpBit("reset irq", 1'b0, irq);
      foreach (addrs[i])
      begin
         rd(addrs[i]);
         cmpWord("reset value", 32'h0, rdata);
      end
      wr(8'h1c, 32'hffffffff);
      rd(8'h1c);
      cmpWord("unmapped", 32'h0, rdata);
      wr(OFS_CMP_P, 32'hffffffff);
      rd(OFS_CMP_P);
      cmpWord("cmp p width", 32'h7, rdata);
      wr(OFS_CMP_A, 32'hffffffff);
      rd(OFS_CMP_A);
      cmpWord("cmp a width", 32'h3ff, rdata);
      $display("done reset");
   endtask : t_reset

   task automatic t_clear_a;
      run(ctl(MODE_COMPARE, ACT_TOGGLE, 1'b1, 1'b0, 1'b1), 10'd200, 3'd1,
          250, 10'd50, 2'b01, 1'b0);
      $display("done clear on A");
   endtask : t_clear_a

   task automatic t_clear_p;
      run(ctl(MODE_COMPARE, ACT_TOGGLE, 1'b1, 1'b1, 1'b0), 10'd300, 3'd1,
          200, 10'd73, 2'b10, 1'b0);
      run(ctl(MODE_COMPARE, ACT_LOW, 1'b1, 1'b1, 1'b0), 10'd5, 3'd1,
          200, 10'd73, 2'b11, 1'b1);
      $display("done clear on P");
   endtask : t_clear_p

   task automatic t_overflow;
      run(ctl(MODE_COMPARE, ACT_LOW, 1'b1, 1'b0, 1'b0), 10'd0, 3'd0,
          1030, 10'd7, 2'b10, 1'b1);
      run(ctl(MODE_COMPARE, ACT_TOGGLE, 1'b1, 1'b0, 1'b1), 10'd0, 3'd1,
          1030, 10'd7, 2'b00, 1'b1);
      $display("done overflow");
   endtask : t_overflow

   task automatic t_actions;
      for (int k = 0; k < 4; k++)
      begin
         run(ctl(MODE_COMPARE, k[1:0], 1'b1, 1'b0, 1'b1), 10'd10, 3'd1,
             16, 10'd6, 2'b01, ~k[0]);
      end
      $display("done actions");
   endtask : t_actions

   task automatic t_modes;
      run(ctl(MODE_TIMER, ACT_TOGGLE, 1'b0, 1'b0, 1'b1), 10'd10, 3'd1,
          16, 10'd6, 2'b01, 1'b0);
      cmpBit("timer mode pin enable", 1'b0, tmOutEnable);
      // A match inside the P period must not clear while P governs
      run(ctl(MODE_PWM, ACT_NONE, 1'b0, 1'b0, 1'b1), 10'd5, 3'd1,
          200, 10'd73, 2'b11, 1'b0);
      cmpBit("pwm mode pin enable", 1'b1, tmOutEnable);
      // Swap bit set: A governs the period although clear-select is low
      run(ctl(MODE_PWM, ACT_NONE, 1'b0, 1'b0, 1'b0) | 32'h2, 10'd10,
          3'd1, 16, 10'd6, 2'b01, 1'b0);
      wr(OFS_CONTROL, 32'h40);
      @(posedge ref_clk);
      cmpBit("spare mode pin enable", 1'b0, tmOutEnable);
      wr(OFS_CONTROL, 32'h0);
      @(posedge ref_clk);
      cmpBit("compare mode pin enable", 1'b1, tmOutEnable);
      $display("done modes");
   endtask : t_modes

   task automatic t_irq;
      maskVal = 2'b01;
      wr(OFS_MASK, 32'h1);
      rd(OFS_MASK);
      cmpWord("mask", 32'h1, rdata);
      run(ctl(MODE_COMPARE, ACT_NONE, 1'b0, 1'b0, 1'b1), 10'd10, 3'd1,
          16, 10'd6, 2'b01, 1'b0);
      // A event with only P unmasked must stay quiet
      maskVal = 2'b10;
      wr(OFS_MASK, 32'h2);
      run(ctl(MODE_COMPARE, ACT_NONE, 1'b0, 1'b0, 1'b1), 10'd10, 3'd1,
          16, 10'd6, 2'b01, 1'b0);
      // P event with P unmasked must raise the line
      run(ctl(MODE_COMPARE, ACT_NONE, 1'b0, 1'b0, 1'b0), 10'd300, 3'd1,
          200, 10'd73, 2'b10, 1'b0);
      $display("done interrupt");
   endtask : t_irq

   // ************************************************************
   // Verdict, main sequence and watchdog
   // ************************************************************
   task automatic final_report;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : final_report

   initial
   begin
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      t_reset();
      t_clear_a();
      t_clear_p();
      t_overflow();
      t_actions();
      t_modes();
      t_irq();
      final_report();
   end

   // Tests need under 5000 cycles; four times that means a hang
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      miscompares++;
      final_report();
   end

endmodule : tb
